/* hdl/dcr_pkg.sv */
// Constants and register map of the converter configuration register bank.
// Overview of operation
// - Sixteen alarm suppress bits, reset all ones
// - Bits 15/14 suppress zero-clock alarms A/B
// - Bits 13/12/11 suppress FIFO pointer alarms
// - Bit 6 suppresses data clock loss alarm
// - Bit 5 gates output shutoff, not pin
// - Bits 4/3 suppress pattern mismatch A/B
// - Channel A offset, 13 bits, reset zero
// - Read start offset loads pointer on sync
// - Channel B offset in low 13 bits
// - Writing channel B offset pulses offset sync
// - Coarse scale 4 bits, current steps, reset 1111
// - Bit 11 puts fuse block to sleep
// - Bit 8 powers down temperature sensor
// - Bit 7 enables sample clock receiver, reset 1
// - Bits 6/5 sleep channel A/B
// - First test word, 14 bits, reset 3A7A
// - Second test word, 14 bits, reset 36B6
// - Per-channel mismatch alarm on pattern difference
package dcr_pkg;
   localparam int unsigned ADDR_W   = 5;          // Register address width
   localparam int unsigned DATA_W   = 16;         // Register data width
   localparam int unsigned SAMPLE_W = 14;         // Converter sample width
   localparam int unsigned OFFS_W   = 13;         // Offset trim width
   localparam int unsigned PTR_W    = 3;          // FIFO pointer width

   // Register offsets
   localparam logic [ADDR_W-1:0] ALARM_SUPPRESS_OFS   = 5'h07;
   localparam logic [ADDR_W-1:0] CHAN_A_OFFSET_OFS    = 5'h08;
   localparam logic [ADDR_W-1:0] READ_START_OFS       = 5'h09;
   localparam logic [ADDR_W-1:0] SCALE_POWER_OFS      = 5'h0A;
   localparam logic [ADDR_W-1:0] RESERVED_BLOCK_OFS   = 5'h0B;
   localparam logic [ADDR_W-1:0] TEST_WORD_ZERO_OFS   = 5'h0C;
   localparam logic [ADDR_W-1:0] TEST_WORD_ONE_OFS    = 5'h0D;

   // Reset values
   localparam logic [DATA_W-1:0] ALARM_SUPPRESS_RST   = 16'hFFFF;
   localparam logic [DATA_W-1:0] CHAN_A_OFFSET_RST    = 16'h4000;
   localparam logic [DATA_W-1:0] READ_START_RST       = 16'h8000;
   localparam logic [DATA_W-1:0] SCALE_POWER_RST      = 16'hF080;
   localparam logic [DATA_W-1:0] RESERVED_BLOCK_RST   = 16'h1111;
   localparam logic [DATA_W-1:0] TEST_WORD_ZERO_RST   = 16'h3A7A;
   localparam logic [DATA_W-1:0] TEST_WORD_ONE_RST    = 16'h36B6;
   localparam logic [DATA_W-1:0] UNMAPPED_READ        = 16'h0000;

   // Field positions inside the suppress register
   localparam int unsigned SUP_ZCLK_A   = 15;
   localparam int unsigned SUP_ZCLK_B   = 14;
   localparam int unsigned SUP_COLL_A   = 13;
   localparam int unsigned SUP_NEAR_A   = 12;
   localparam int unsigned SUP_COLL_B   = 11;
   localparam int unsigned SUP_CLK_GONE = 6;
   localparam int unsigned SUP_SHUTOFF  = 5;
   localparam int unsigned SUP_PAT_A    = 4;
   localparam int unsigned SUP_PAT_B    = 3;

   // Field positions inside the scale and power register, then the pointer field of the read start register
   localparam int unsigned SCALE_LSB     = 12;
   localparam int unsigned FUSE_SLEEP    = 11;
   localparam int unsigned TSENSE_SLEEP  = 8;
   localparam int unsigned CLKRECV_ENA   = 7;
   localparam int unsigned SLEEP_A       = 6;
   localparam int unsigned SLEEP_B       = 5;
   localparam int unsigned PTR_LSB       = 13;

   // Writable masks; clear bits are reserved and keep reset value
   localparam logic [DATA_W-1:0] OFFSET_WMASK = 16'h1FFF;
   localparam logic [DATA_W-1:0] SCALE_WMASK  = 16'hF9E0;
   localparam logic [DATA_W-1:0] WORD_WMASK   = 16'h3FFF;
   localparam int unsigned       PAT_LEN      = 8;
endpackage : dcr_pkg

/* hdl/dcr_bank.sv */
// Configuration register bank with offset sync, read pointer and pattern check.
//
// The implementer's own choice: the plain strobed port.
module dcr_bank
   import dcr_pkg::*;
(
   input  wire logic                  clk_i,          // Sample clock, 100 MHz
   input  wire logic                  arst_n_i,       // Async reset, active low
   input  wire logic [ADDR_W-1:0]     addr_i,         // Register address
   input  wire logic [DATA_W-1:0]     wdata_i,        // Write data
   input  wire logic                  wr_i,           // Write strobe
   input  wire logic                  rd_i,           // Read strobe
   output logic      [DATA_W-1:0]     rdata_o,        // Read data, next cycle
   input  wire logic                  sync_i,         // Sync pin, async
   input  wire logic [SAMPLE_W-1:0]   data_a_i,       // Channel A input data
   input  wire logic [SAMPLE_W-1:0]   data_b_i,       // Channel B input data
   input  wire logic [8:0]            alarm_src_i,    // Raw alarm sources
   output logic [8:0]                 alarm_o,        // Unsuppressed alarms
   output logic                       out_off_o,      // Output shutoff request
   output logic [OFFS_W-1:0]          offset_a_o,     // Channel A trim
   output logic [OFFS_W-1:0]          offset_b_o,     // Channel B trim
   output logic                       offset_sync_o,  // Offset sync pulse
   output logic [PTR_W-1:0]           rd_ptr_o,       // FIFO read pointer
   output logic [3:0]                 coarse_o,       // Coarse scale
   output logic                       fuse_sleep_o,   // Fuse sleep
   output logic                       tsense_sleep_o, // Temp sensor sleep
   output logic                       clkrecv_ena_o,  // Clock receiver enable
   output logic                       sleep_a_o,      // Channel A sleep
   output logic                       sleep_b_o,      // Channel B sleep
   output logic                       pat_err_a_o,    // Channel A mismatch
   output logic                       pat_err_b_o     // Channel B mismatch
);

   // Whole module state
   typedef struct packed {
      logic [DATA_W-1:0]   sup;        // Alarm suppress
      logic [DATA_W-1:0]   offa;       // Chan A offset register
      logic [DATA_W-1:0]   rdst;       // Read start and chan B offset
      logic [DATA_W-1:0]   scp;        // Scale and power
      logic [DATA_W-1:0]   w0;         // Test word zero
      logic [DATA_W-1:0]   w1;         // Test word one
      logic [DATA_W-1:0]   rdata;      // Read data
      logic [1:0]          sync_s;     // Sync synchroniser
      logic                sync_d;     // Sync delay for edge
      logic                osync;      // Offset sync pulse
      logic [PTR_W-1:0]    ptr;        // Read pointer
      logic [PTR_W-1:0]    pidx;       // Pattern index
      logic [8:0]          alarm;      // Alarm outputs
      logic                off;        // Shutoff output
      logic                perr_a;     // Mismatch A
      logic                perr_b;     // Mismatch B
   } dcr_state_t;

   dcr_state_t          st_ff;         // Registered state
   dcr_state_t          nxt_st;        // Next state
   logic                sync_rise;     // Rising edge of synced sync
   logic [SAMPLE_W-1:0] exp_word;      // Expected pattern word

   // Words 2..7 lie outside this bank; fixed at documented defaults
   function automatic logic [SAMPLE_W-1:0] pat_word(input logic [PTR_W-1:0] i,
                                                    input logic [DATA_W-1:0] a,
                                                    input logic [DATA_W-1:0] b);
      logic [SAMPLE_W-1:0] r;
      r = '0;
      unique case (i)
         3'h0: r = a[SAMPLE_W-1:0];
         3'h1: r = b[SAMPLE_W-1:0];
         3'h2: r = 14'h2AEA;
         3'h3: r = 14'h0545;
         3'h4: r = 14'h1A1A;
         3'h5: r = 14'h1616;
         3'h6: r = 14'h2AAA;
         3'h7: r = 14'h06C6;
      endcase
      return r;
   endfunction : pat_word

   // Write decode, used by every writable register
   function automatic logic hit(input logic w, input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] o);
      return w && (a == o);
   endfunction : hit

   assign sync_rise = st_ff.sync_s[1] && !st_ff.sync_d;
   // Test word zero expected on the sync rising edge
   assign exp_word  = pat_word(sync_rise ? 3'h0 : st_ff.pidx, st_ff.w0, st_ff.w1);

   // Next-state logic
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.sync_s = {st_ff.sync_s[0], sync_i};
      nxt_st.sync_d = st_ff.sync_s[1];
      nxt_st.osync  = 1'b0;
      // Register writes; reserved bits keep their reset values
      if (hit(wr_i, addr_i, ALARM_SUPPRESS_OFS)) begin
         nxt_st.sup = wdata_i;
      end
      if (hit(wr_i, addr_i, CHAN_A_OFFSET_OFS)) begin
         nxt_st.offa = (wdata_i & OFFSET_WMASK)
                     | (CHAN_A_OFFSET_RST & ~OFFSET_WMASK);
      end
      if (hit(wr_i, addr_i, READ_START_OFS)) begin
         nxt_st.rdst  = wdata_i;
         nxt_st.osync = 1'b1;
      end
      if (hit(wr_i, addr_i, SCALE_POWER_OFS)) begin
         nxt_st.scp = (wdata_i & SCALE_WMASK) | (SCALE_POWER_RST & ~SCALE_WMASK);
      end
      if (hit(wr_i, addr_i, TEST_WORD_ZERO_OFS)) begin
         nxt_st.w0 = wdata_i & WORD_WMASK;
      end
      if (hit(wr_i, addr_i, TEST_WORD_ONE_OFS)) begin
         nxt_st.w1 = wdata_i & WORD_WMASK;
      end
      // Read mux; unmapped addresses read zero
      if (rd_i) begin
         unique case (addr_i)
            ALARM_SUPPRESS_OFS: nxt_st.rdata = st_ff.sup;
            CHAN_A_OFFSET_OFS:  nxt_st.rdata = st_ff.offa;
            READ_START_OFS:     nxt_st.rdata = st_ff.rdst;
            SCALE_POWER_OFS:    nxt_st.rdata = st_ff.scp;
            RESERVED_BLOCK_OFS: nxt_st.rdata = RESERVED_BLOCK_RST;
            TEST_WORD_ZERO_OFS: nxt_st.rdata = st_ff.w0;
            TEST_WORD_ONE_OFS:  nxt_st.rdata = st_ff.w1;
            default:            nxt_st.rdata = UNMAPPED_READ;
         endcase
      end else begin
         nxt_st.rdata = '0;
      end
      // Sample-side sync reloads the read pointer, otherwise it advances
      if (sync_rise) begin
         nxt_st.ptr  = st_ff.rdst[PTR_LSB +: PTR_W];
         nxt_st.pidx = 3'h1;
      end else begin
         nxt_st.ptr  = st_ff.ptr + 3'h1;
         nxt_st.pidx = st_ff.pidx + 3'h1;
      end
      // Pattern compare per channel, suppressible
      nxt_st.perr_a = (data_a_i != exp_word) && !st_ff.sup[SUP_PAT_A];
      nxt_st.perr_b = (data_b_i != exp_word) && !st_ff.sup[SUP_PAT_B];
      // Alarm gating: order 15,14,13,12,11,6,4,3 then spare bit
      nxt_st.alarm[0] = alarm_src_i[0] && !st_ff.sup[SUP_ZCLK_A];
      nxt_st.alarm[1] = alarm_src_i[1] && !st_ff.sup[SUP_ZCLK_B];
      nxt_st.alarm[2] = alarm_src_i[2] && !st_ff.sup[SUP_COLL_A];
      nxt_st.alarm[3] = alarm_src_i[3] && !st_ff.sup[SUP_NEAR_A];
      nxt_st.alarm[4] = alarm_src_i[4] && !st_ff.sup[SUP_COLL_B];
      nxt_st.alarm[5] = alarm_src_i[5] && !st_ff.sup[SUP_CLK_GONE];
      nxt_st.alarm[6] = alarm_src_i[6] && !st_ff.sup[SUP_PAT_A];
      nxt_st.alarm[7] = alarm_src_i[7] && !st_ff.sup[SUP_PAT_B];
      nxt_st.alarm[8] = alarm_src_i[8];
      // Shutoff path: only bit 5 gates it; pin alarms stay independent
      nxt_st.off = (alarm_src_i[0] | alarm_src_i[1] | alarm_src_i[2] | alarm_src_i[4]
                    | alarm_src_i[5]) && !st_ff.sup[SUP_SHUTOFF];
   end

   // State register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff       <= '0;
         st_ff.sup   <= ALARM_SUPPRESS_RST;
         st_ff.offa  <= CHAN_A_OFFSET_RST;
         st_ff.rdst  <= READ_START_RST;
         st_ff.scp   <= SCALE_POWER_RST;
         st_ff.w0    <= TEST_WORD_ZERO_RST;
         st_ff.w1    <= TEST_WORD_ONE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs straight from flops
   assign rdata_o        = st_ff.rdata;
   assign alarm_o        = st_ff.alarm;
   assign out_off_o      = st_ff.off;
   assign offset_a_o     = st_ff.offa[OFFS_W-1:0];
   assign offset_b_o     = st_ff.rdst[OFFS_W-1:0];
   assign offset_sync_o  = st_ff.osync;
   assign rd_ptr_o       = st_ff.ptr;
   assign coarse_o       = st_ff.scp[SCALE_LSB +: 4];
   assign fuse_sleep_o   = st_ff.scp[FUSE_SLEEP];
   assign tsense_sleep_o = st_ff.scp[TSENSE_SLEEP];
   assign clkrecv_ena_o  = st_ff.scp[CLKRECV_ENA];
   assign sleep_a_o      = st_ff.scp[SLEEP_A];
   assign sleep_b_o      = st_ff.scp[SLEEP_B];
   assign pat_err_a_o    = st_ff.perr_a;
   assign pat_err_b_o    = st_ff.perr_b;

   // Checks; every answer but the suppress reset check shows one cycle after its cause
   // Write of the channel A offset
   sequence s_wr_a;
      wr_i && addr_i == CHAN_A_OFFSET_OFS;
   endsequence

   // Write of read start and channel B offset
   sequence s_wr_b;
      wr_i && addr_i == READ_START_OFS;
   endsequence

   // Write of scale and power
   sequence s_wr_scp;
      wr_i && addr_i == SCALE_POWER_OFS;
   endsequence

   // Channel B write with no second one behind it
   sequence s_b_single;
      s_wr_b ##1 !(wr_i && addr_i == READ_START_OFS);
   endsequence

   // Suppress word after reset
   AST_SUP_RESET: assert property (@(posedge clk_i)
      $rose(arst_n_i)
      |-> st_ff.sup == ALARM_SUPPRESS_RST)
      else $error("suppress reset wrong");

   // Bit 15 holds back zero clock A
   AST_ZCLK_A: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[0] && st_ff.sup[SUP_ZCLK_A]
      |=> !alarm_o[0])
      else $error("zero clock A not suppressed");

   // Bit 14 holds back zero clock B
   AST_ZCLK_B: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[1] && st_ff.sup[SUP_ZCLK_B]
      |=> !alarm_o[1])
      else $error("zero clock B not suppressed");

   // Unmasked collision A passes
   AST_COLL_A: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[2] && !st_ff.sup[SUP_COLL_A]
      |=> alarm_o[2])
      else $error("collision A lost");

   // Bit 12 holds back near A
   AST_NEAR_A: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[3] && st_ff.sup[SUP_NEAR_A]
      |=> !alarm_o[3])
      else $error("near A not suppressed");

   // Unmasked collision B passes
   AST_COLL_B: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[4] && !st_ff.sup[SUP_COLL_B]
      |=> alarm_o[4])
      else $error("collision B lost");

   // Unmasked clock loss passes
   AST_CLK_GONE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[5] && !st_ff.sup[SUP_CLK_GONE]
      |=> alarm_o[5])
      else $error("clock gone lost");

   // Bit 5 blocks the shutoff
   AST_SHUTOFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_ff.sup[SUP_SHUTOFF]
      |=> !out_off_o)
      else $error("shutoff not masked");

   // Clock loss shuts off when unmasked
   AST_SHUTOFF_ON: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[5] && !st_ff.sup[SUP_SHUTOFF]
      |=> out_off_o)
      else $error("shutoff missing");

   // Shutoff mask leaves pin alarms alone
   AST_PIN_FREE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      alarm_src_i[0] && st_ff.sup[SUP_SHUTOFF] && !st_ff.sup[SUP_ZCLK_A]
      |=> alarm_o[0])
      else $error("shutoff mask hit pin alarm");

   // Bit 4 silences mismatch A
   AST_PAT_MASK_A: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_ff.sup[SUP_PAT_A]
      |=> !pat_err_a_o)
      else $error("mismatch A not masked");

   // Bit 3 silences mismatch B
   AST_PAT_MASK_B: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      st_ff.sup[SUP_PAT_B]
      |=> !pat_err_b_o)
      else $error("mismatch B not masked");

   // Channel A trim taken
   AST_OFFA: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_a
      |=> offset_a_o == $past(wdata_i[OFFS_W-1:0]))
      else $error("chan A offset not stored");

   // Reserved top bits keep their value
   AST_OFFA_RSVD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_a
      |=> st_ff.offa[DATA_W-1:OFFS_W] == CHAN_A_OFFSET_RST[DATA_W-1:OFFS_W])
      else $error("chan A reserved bits changed");

   // Sync loads the start position
   AST_PTR_LOAD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      sync_rise
      |=> rd_ptr_o == $past(st_ff.rdst[PTR_LSB +: PTR_W]))
      else $error("pointer not loaded");

   // Pointer steps by one between syncs
   AST_PTR_STEP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      arst_n_i && !sync_rise
      |=> rd_ptr_o == $past(rd_ptr_o) + 3'h1)
      else $error("pointer did not step");

   // Channel B trim taken
   AST_OFFB: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_b
      |=> offset_b_o == $past(wdata_i[OFFS_W-1:0]))
      else $error("chan B offset not stored");

   // Write raises the offset sync
   AST_AUTOSYNC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_b
      |=> offset_sync_o)
      else $error("auto sync missing");

   // Sync pulse lasts one cycle
   AST_SYNC_ONE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_b_single
      |=> !offset_sync_o)
      else $error("auto sync too long");

   // Coarse scale taken
   AST_COARSE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_scp
      |=> coarse_o == $past(wdata_i[SCALE_LSB +: 4]))
      else $error("coarse scale not stored");

   // Fuse sleep taken
   AST_FUSE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_scp
      |=> fuse_sleep_o == $past(wdata_i[FUSE_SLEEP]))
      else $error("fuse sleep not stored");

   // Sensor sleep taken
   AST_TSENSE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_scp
      |=> tsense_sleep_o == $past(wdata_i[TSENSE_SLEEP]))
      else $error("sensor sleep not stored");

   // Receiver enable taken
   AST_CLKRECV: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_scp
      |=> clkrecv_ena_o == $past(wdata_i[CLKRECV_ENA]))
      else $error("receiver enable not stored");

   // Channel A sleep taken
   AST_SLEEP_A: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_scp
      |=> sleep_a_o == $past(wdata_i[SLEEP_A]))
      else $error("sleep A not stored");

   // Channel B sleep taken
   AST_SLEEP_B: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      s_wr_scp
      |=> sleep_b_o == $past(wdata_i[SLEEP_B]))
      else $error("sleep B not stored");

   // First test word, top bits dropped
   AST_W0: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      wr_i && addr_i == TEST_WORD_ZERO_OFS
      |=> st_ff.w0 == ($past(wdata_i) & WORD_WMASK))
      else $error("test word zero not stored");

   // Second test word, top bits dropped
   AST_W1: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      wr_i && addr_i == TEST_WORD_ONE_OFS
      |=> st_ff.w1 == ($past(wdata_i) & WORD_WMASK))
      else $error("test word one not stored");

   // Unmasked difference raises mismatch A
   AST_PERR_A: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      data_a_i != exp_word && !st_ff.sup[SUP_PAT_A]
      |=> pat_err_a_o)
      else $error("mismatch A missing");

   // Reserved register reads its fixed value
   AST_RSVD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      rd_i && addr_i == RESERVED_BLOCK_OFS
      |=> rdata_o == RESERVED_BLOCK_RST)
      else $error("reserved read wrong");

endmodule : dcr_bank

/* test/dcr_bank_test.sv */
// Self-checking bench for the converter configuration register bank.
module dcr_bank_test import dcr_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   logic                clk_i, arst_n_i, wr_i, rd_i, sync_i;   // Clock, reset, strobes, sync
   logic [ADDR_W-1:0]   addr_i;                               // Register address
   logic [DATA_W-1:0]   wdata_i, rdata_o;                     // Bus data
   logic [SAMPLE_W-1:0] data_a_i, data_b_i;                   // Pattern stream
   logic [8:0]          alarm_src_i, alarm_o;                 // Raw and passed alarms
   logic [OFFS_W-1:0]   offset_a_o, offset_b_o;               // Trims
   logic [PTR_W-1:0]    rd_ptr_o, idx;                        // Pointer, pattern index
   logic [3:0]          coarse_o;                             // Coarse scale
   logic                out_off_o, offset_sync_o, fuse_sleep_o, tsense_sleep_o;
   logic                clkrecv_ena_o, sleep_a_o, sleep_b_o, pat_err_a_o, pat_err_b_o;
   logic                pat_on, bad_a, bad_b;                 // Stream control
   int                  bad_count, checks_done, cyc;          // Tallies
   logic [15:0]         rst_t [7] = '{16'hFFFF, 16'h4000, 16'h8000, 16'hF080,
                                      16'h1111, 16'h3A7A, 16'h36B6};
   logic [15:0]         wm    [7] = '{16'hFFFF, 16'h1FFF, 16'hFFFF, 16'hF9E0,
                                      16'h0000, 16'h3FFF, 16'h3FFF};
   logic [15:0]         vals  [3] = '{16'h5A5A, 16'hA5A5, 16'h0000};
   int                  sp    [8] = '{15, 14, 13, 12, 11, 6, 4, 3}; // Suppress bit per source
   logic [13:0]         pat   [8];                            // Expected test words

   dcr_bank dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sync_i(sync_i), .data_a_i(data_a_i),
      .data_b_i(data_b_i), .alarm_src_i(alarm_src_i), .alarm_o(alarm_o),
      .out_off_o(out_off_o), .offset_a_o(offset_a_o), .offset_b_o(offset_b_o),
      .offset_sync_o(offset_sync_o), .rd_ptr_o(rd_ptr_o), .coarse_o(coarse_o),
      .fuse_sleep_o(fuse_sleep_o), .tsense_sleep_o(tsense_sleep_o),
      .clkrecv_ena_o(clkrecv_ena_o), .sleep_a_o(sleep_a_o), .sleep_b_o(sleep_b_o),
      .pat_err_a_o(pat_err_a_o), .pat_err_b_o(pat_err_b_o));

   // Free-running 100 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Pattern source; word zero lands in the cycle the sync edge is seen
   always @(posedge clk_i) begin
      if (pat_on) begin
         data_a_i <= pat[idx] ^ {13'h0000, bad_a};
         data_b_i <= pat[idx] ^ {13'h0000, bad_b};
         idx      <= idx + 3'h1;
      end
   end

   // Hang guard, far beyond the few hundred cycles the tests need
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         complete_run();
      end
   end

   // Compare and tally
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // One-cycle write; returns in the cycle after, when the effect shows
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      wr_i    <= 1'b1;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      #1;
   endtask : wr

   // One-cycle read; data taken in the single cycle it stands
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
      @(posedge clk_i);
      rd_i   <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1 v = rdata_o;
   endtask : rd

   // Closing report
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run

   // Main sequence
   initial begin
      logic [15:0] v;
      logic [15:0] w;
      {arst_n_i, wr_i, rd_i, sync_i, pat_on, bad_a, bad_b} = '0;
      {addr_i, wdata_i, data_a_i, data_b_i, alarm_src_i, idx} = '0;
      {bad_count, checks_done, cyc} = '0;
      pat = '{14'h0ABC, 14'h1DEF, 14'h2AEA, 14'h0545, 14'h1A1A, 14'h1616, 14'h2AAA, 14'h06C6};
      repeat (20) @(posedge clk_i);
      arst_n_i <= 1'b1;
      #1 chk("reset fields", 16'h01E4, 16'({coarse_o, fuse_sleep_o, tsense_sleep_o,
         clkrecv_ena_o, sleep_a_o, sleep_b_o}));
      for (int i = 0; i < 7; i++) begin
         rd(5'(7 + i), v);
         chk("reset value", rst_t[i], v);
      end
      rd(5'h1F, v);
      chk("unmapped read", 16'h0000, v);
      @(posedge clk_i);
      #1 chk("idle read data", 16'h0000, rdata_o);
      $display("test reset_values done");
      // Write then read back every register; reserved bits keep reset value
      for (int r = 0; r < 3; r++) begin
         w = vals[r];
         for (int i = 0; i < 7; i++) begin
            wr(5'(7 + i), w);
            chk("offset sync", 16'(i == 2), 16'(offset_sync_o));
         end
         for (int i = 0; i < 7; i++) begin
            rd(5'(7 + i), v);
            chk("readback", (w & wm[i]) | (rst_t[i] & ~wm[i]), v);
         end
         chk("power fields", 16'({w[15:12], w[11], w[8], w[7], w[6], w[5]}),
            16'({coarse_o, fuse_sleep_o, tsense_sleep_o, clkrecv_ena_o,
            sleep_a_o, sleep_b_o}));
         chk("offset a", 16'(w[12:0]), 16'(offset_a_o));
         chk("offset b", 16'(w[12:0]), 16'(offset_b_o));
      end
      wr(5'h09, 16'hC123);
      chk("offset sync", 16'h0001, 16'(offset_sync_o));
      @(posedge clk_i);
      #1 chk("offset sync end", 16'h0000, 16'(offset_sync_o));
      wr(5'h0C, 16'hCABC); // High bits reserved, dropped
      wr(5'h0D, 16'h1DEF);
      $display("test write_readback done");
      // Each suppress bit blocks exactly its own source
      @(posedge clk_i) alarm_src_i <= 9'h1FF;
      for (int i = 0; i < 8; i++) begin
         wr(5'h07, 16'h0001 << sp[i]);
         repeat (2) @(posedge clk_i);
         #1 chk("alarm", 16'(9'h1FF & ~(9'h001 << i)), 16'(alarm_o));
         chk("shutoff", 16'h0001, 16'(out_off_o));
      end
      wr(5'h07, 16'h0020);
      repeat (2) @(posedge clk_i);
      #1 chk("alarm pin path", 16'h01FF, 16'(alarm_o));
      chk("shutoff masked", 16'h0000, 16'(out_off_o));
      wr(5'h07, 16'h0000);
      for (int j = 0; j < 9; j++) begin
         @(posedge clk_i) alarm_src_i <= 9'h001 << j;
         repeat (2) @(posedge clk_i);
         #1 chk("shutoff cause", 16'((9'h037 >> j) & 9'h001), 16'(out_off_o));
      end
      wr(5'h07, 16'hFFFF);
      @(posedge clk_i) alarm_src_i <= 9'h1FF;
      repeat (2) @(posedge clk_i);
      #1 chk("all suppressed", 16'h0100, 16'(alarm_o));
      $display("test alarm_suppress done");
      // Sync loads the read pointer and aligns the pattern check
      wr(5'h07, 16'h0000);
      bad_b <= 1'b1;
      @(posedge clk_i) sync_i <= 1'b1;
      @(posedge clk_i) pat_on <= 1'b1;
      @(posedge clk_i);
      @(posedge clk_i);
      #1 chk("read pointer load", 16'h0006, 16'(rd_ptr_o));
      @(posedge clk_i);
      #1 chk("read pointer step", 16'h0007, 16'(rd_ptr_o));
      repeat (16) @(posedge clk_i);
      #1 chk("match a", 16'h0000, 16'(pat_err_a_o));
      chk("mismatch b", 16'h0001, 16'(pat_err_b_o));
      @(posedge clk_i) bad_a <= 1'b1;
      wr(5'h07, 16'h0008);
      repeat (3) @(posedge clk_i);
      #1 chk("mismatch a", 16'h0001, 16'(pat_err_a_o));
      chk("masked b", 16'h0000, 16'(pat_err_b_o));
      wr(5'h07, 16'h0010);
      repeat (3) @(posedge clk_i);
      #1 chk("masked a", 16'h0000, 16'(pat_err_a_o));
      chk("mismatch b", 16'h0001, 16'(pat_err_b_o));
      $display("test sync_pattern done");
      complete_run();
   end
endmodule : dcr_bank_test
